// >>> hdl/bsfs_sequencer.v
// Soft-start and feedback undervoltage shutdown sequencer
//
// Functional notes
// RULE1: Soft start lasts 1024 switching-clock cycles after enable rises.
// RULE2: Start-up about 3.5 ms at 300 kHz, 1.75 ms at 600 kHz.
// RULE3: Enable below threshold clears the soft-start counter to zero.
// RULE4: Enable low keeps the high-side driver off.
// RULE5: Feedback compared against undervoltage threshold to catch shorts.
// RULE6: Filtered undervoltage turns both drivers off and latches.
// RULE7: Latch clears only by supply cycling, i.e. reset.
// RULE8: Low-side switch discharges output at start of start-up.
// RULE9: Comparator blanked for first half of start-up count.
// RULE10: Threshold is half the ramping soft-start reference.
// RULE11: Short during start-up trips the same shutdown latch.
// RULE12: Reference ramps monotonically to full scale, then holds.
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_defines.vh"
module bsfs_sequencer #(
    parameter FAST_VARIANT = 0,
    parameter SS_CYCLES = `BSFS_SS_CYCLES,
    parameter DISCHARGE_CYCLES = 8,
    parameter UV_FILTER_CYC = `BSFS_UV_FILTER_CYC
) (
    // Clock and reset (reset stands for supply cycling)
    input wire core_clk,
    input wire rst_n,
    // Enable comparator: high while the pin is above its threshold
    input wire enable_above,
    // Digitised feedback_input, same scale as the reference
    input wire [`BSFS_REF_WIDTH-1:0] feedback_input,
    // Gate requests from the PWM modulator
    input wire pwm_high_req,
    input wire pwm_low_req,
    // Gate drivers
    output reg high_gate,
    output reg low_gate,
    // Reference for the error amplifier and status
    output reg [`BSFS_REF_WIDTH-1:0] ss_reference,
    output reg ss_done,
    output reg feedback_undervoltage_shutdown,
    output reg sw_tick
);
    // --------------------------------------------------------------
    // Switching-clock tick
    // --------------------------------------------------------------
    localparam [7:0] SW_DIV = FAST_VARIANT ? `BSFS_SW_DIV_600K :
                                             `BSFS_SW_DIV_300K;
    localparam [`BSFS_SS_WIDTH-1:0] SS_END = SS_CYCLES[`BSFS_SS_WIDTH-1:0];
    localparam [`BSFS_SS_WIDTH-1:0] SS_HALF = SS_END >> 1;

    localparam ST_OFF = 2'b00;
    localparam ST_DISCH = 2'b01;
    localparam ST_RAMP = 2'b10;
    localparam ST_RUN = 2'b11;

    reg [7:0] div_count;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`BSFS_SS_WIDTH-1:0] ss_count;
    reg [3:0] disch_count;
    reg uv_armed;
    wire uv_below;
    wire uv_trip;
    reg [`BSFS_REF_WIDTH-1:0] next_reference;

    // Tick sets the pace of the soft-start count [RULE2]
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= 8'h00;
            sw_tick <= 1'b0;
        end else if (div_count == SW_DIV - 8'h01) begin
            div_count <= 8'h00;
            sw_tick <= 1'b1;
        end else begin
            div_count <= div_count + 8'h01;
            sw_tick <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (enable_above)
                    next_state = ST_DISCH;
            end
            ST_DISCH: begin
                if (disch_count == DISCHARGE_CYCLES[3:0] && sw_tick)
                    next_state = ST_RAMP;
            end
            ST_RAMP: begin
                if (ss_count == SS_END - 1'b1 && sw_tick)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!enable_above)
            next_state = ST_OFF;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            ss_count <= {`BSFS_SS_WIDTH{1'b0}};
            disch_count <= 4'h0;
        end else begin
            state <= next_state;
            if (!enable_above) begin
                ss_count <= {`BSFS_SS_WIDTH{1'b0}}; // [RULE3]
                disch_count <= 4'h0;
            end else if (state == ST_DISCH && sw_tick) begin
                disch_count <= disch_count + 4'h1;
            end else if (state == ST_RAMP && sw_tick &&
                         ss_count != SS_END) begin
                ss_count <= ss_count + 1'b1; // [RULE1]
            end else if (next_state == ST_RUN) begin
                ss_count <= SS_END;
            end
        end
    end

    // Reference ramp: low counter bits used unscaled, full scale held at the end
    always @* begin
        if (ss_count >= SS_END)
            next_reference = `BSFS_REF_FULL; // [RULE12]
        else
            next_reference = ss_count[`BSFS_SS_WIDTH-2:0]; // [RULE12]
    end

    // --------------------------------------------------------------
    // Undervoltage detection and latch
    // --------------------------------------------------------------
    // Threshold is half the reference, so 0.4 V once at 0.8 V
    assign uv_below = ({1'b0, feedback_input} < // [RULE5]
        {2'b00, ss_reference[`BSFS_REF_WIDTH-1:1]}); // [RULE10]

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            uv_armed <= 1'b0;
        else
            uv_armed <= enable_above &&
                        (state == ST_RUN ||
                         (state == ST_RAMP && ss_count >= SS_HALF)); // [RULE9]
    end

    bsfs_uv_filter #(
        .CYCLES(UV_FILTER_CYC),
        .WIDTH(8)
    ) u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .arm(uv_armed),
        .below(uv_below),
        .tripped(uv_trip)
    );

    // Only reset clears the latch; enable cannot, to avoid hiccup restart
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            feedback_undervoltage_shutdown <= 1'b0; // [RULE7]
        else if (uv_trip)
            feedback_undervoltage_shutdown <= 1'b1; // [RULE6] [RULE11]
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_gate <= 1'b0;
            low_gate <= 1'b0;
            ss_reference <= {`BSFS_REF_WIDTH{1'b0}};
            ss_done <= 1'b0;
        end else begin
            ss_reference <= enable_above ? next_reference :
                            {`BSFS_REF_WIDTH{1'b0}};
            // Done drops with enable on the same edge as the reference
            ss_done <= enable_above && (state == ST_RUN);
            if (feedback_undervoltage_shutdown || uv_trip) begin
                high_gate <= 1'b0; // [RULE6]
                low_gate <= 1'b0;
            end else if (!enable_above || state == ST_OFF) begin
                high_gate <= 1'b0; // [RULE4]
                low_gate <= 1'b0;
            end else if (state == ST_DISCH) begin
                high_gate <= 1'b0;
                low_gate <= 1'b1; // [RULE8]
            end else begin
                high_gate <= pwm_high_req;
                low_gate <= pwm_low_req && !pwm_high_req;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/bsfs_uv_filter.v
// Digital filter that qualifies the feedback undervoltage comparator
`timescale 1ns/1ps
`default_nettype none
module bsfs_uv_filter #(
    parameter CYCLES = 100,
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Comparator result and qualified fault
    input wire arm,
    input wire below,
    output reg tripped
);
    reg [WIDTH-1:0] count;

    // Fault must persist for CYCLES clocks; a glitch restarts the wait
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
            tripped <= 1'b0;
        end else if (!(arm && below)) begin
            count <= {WIDTH{1'b0}};
            tripped <= 1'b0;
        end else if (count == CYCLES[WIDTH-1:0] - 1'b1) begin
            tripped <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> inc/bsfs_defines.vh
// Constants for the soft-start and fault sequencer
`ifndef BSFS_DEFINES_VH
`define BSFS_DEFINES_VH
// Soft-start length in switching-clock cycles
`define BSFS_SS_CYCLES 1024
`define BSFS_SS_WIDTH 11
// Start-up times, microseconds, per variant
`define BSFS_SS_TIME_300K_US 3500
`define BSFS_SS_TIME_600K_US 1750
// Digital reference full scale (0.8 V maps to this code)
`define BSFS_REF_WIDTH 10
`define BSFS_REF_FULL 10'h3FF
// Undervoltage filter: time in ns and derived cycles at 50 MHz
`define BSFS_CLK_PERIOD_NS 20
`define BSFS_UV_FILTER_NS 2000
`define BSFS_UV_FILTER_CYC (`BSFS_UV_FILTER_NS / `BSFS_CLK_PERIOD_NS)
// Switching-clock dividers: 50 MHz / 300 kHz and 50 MHz / 600 kHz, rounded down
`define BSFS_SW_DIV_300K 8'hA6
`define BSFS_SW_DIV_600K 8'h53
`endif

// >>> tb/bsfs_chk.sv
// Assertion checker for the soft-start and fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_defines.vh"
module bsfs_chk #(
    parameter FAST_VARIANT = 0,
    parameter SS_CYCLES = `BSFS_SS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Controller inputs
    input wire logic enable_above,
    input wire logic [`BSFS_REF_WIDTH-1:0] feedback_input,
    input wire logic pwm_high_req,
    input wire logic pwm_low_req,
    // Controller outputs
    input wire logic high_gate,
    input wire logic low_gate,
    input wire logic [`BSFS_REF_WIDTH-1:0] ss_reference,
    input wire logic ss_done,
    input wire logic feedback_undervoltage_shutdown,
    input wire logic sw_tick
);
    localparam int DIV = FAST_VARIANT ? `BSFS_SW_DIV_600K : `BSFS_SW_DIV_300K;
    wire uv = feedback_undervoltage_shutdown;
    logic [7:0] gap;
    logic seen;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Clocks since the last tick; first period after reset is not judged
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else begin
            gap <= sw_tick ? 8'h01 : gap + 8'h01;
            seen <= seen | sw_tick;
        end
    end
    property p_en_off;
        !enable_above |=> !high_gate && ss_reference == 0 && !ss_done;
    endproperty
    a_en_off: assert property (p_en_off)
        else $error("enable low not off");
    property p_sticky;
        uv |=> uv;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("fault latch cleared");
    property p_latch_off;
        uv |=> !high_gate && !low_gate;
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("gate on in fault");
    property p_mono;
        enable_above && !uv |=> uv || ss_reference >= $past(ss_reference);
    endproperty
    a_mono: assert property (p_mono)
        else $error("reference fell");
    property p_done_full;
        ss_done |-> ss_reference == `BSFS_REF_FULL;
    endproperty
    a_done_full: assert property (p_done_full)
        else $error("done not full");
    property p_tick_pulse;
        sw_tick |=> !sw_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("tick too long");
    property p_tick_gap;
        sw_tick && seen |-> gap == DIV;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("tick period wrong");
    property p_blank;
        $rose(uv) |-> ss_done || ss_reference >= SS_CYCLES / 2;
    endproperty
    a_blank: assert property (p_blank)
        else $error("fault while blanked");
    // The latch sets one edge after the filter trips, so look two back
    property p_uv_cause;
        $rose(uv) |-> $past(feedback_input, 2) < ($past(ss_reference, 2) >> 1);
    endproperty
    a_uv_cause: assert property (p_uv_cause)
        else $error("fault w/o low fb");
    property p_disch;
        low_gate && !ss_done && ss_reference == 0 |-> !high_gate;
    endproperty
    a_disch: assert property (p_disch)
        else $error("high gate in discharge");
    // Discharge starts on the second edge after enable rises
    property p_disch_start;
        $rose(enable_above) ##1 (enable_above && !uv) |=>
            low_gate && !high_gate;
    endproperty
    a_disch_start: assert property (p_disch_start)
        else $error("no discharge at start");
    c_done: cover property (ss_done);
    c_fault_ramp: cover property ($rose(uv) && !ss_done);
    c_fault_run: cover property ($rose(uv) && ss_done);
endmodule
`default_nettype wire

// >>> tb/bsfs_power_stage.sv
// Behavioural half-bridge, output filter and feedback divider
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_defines.vh"
module bsfs_power_stage (
    // Clock
    input wire logic core_clk,
    // Gate drives and reference from the controller
    input wire logic high_gate,
    input wire logic low_gate,
    input wire logic [`BSFS_REF_WIDTH-1:0] ss_reference,
    // Short injection
    input wire logic short_on,
    // Divided output voltage
    output var logic [`BSFS_REF_WIDTH-1:0] feedback_input
);
    // Loop abstracted: output tracks the reference unless shorted or pulled low
    initial feedback_input = 10'h000;
    always @(posedge core_clk) begin
        if (short_on || (low_gate && !high_gate))
            feedback_input <= 10'h000;
        else
            feedback_input <= ss_reference;
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench for the soft-start and fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_defines.vh"
module testbench;
    localparam int SS = 16;
    localparam int DIS = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic enable_above = 1'b0;
    logic short_on = 1'b0;
    logic pwm_high_req = 1'b1;
    logic pwm_low_req = 1'b0;
    wire [`BSFS_REF_WIDTH-1:0] fb;
    wire [`BSFS_REF_WIDTH-1:0] ref_v;
    wire high_gate, low_gate, ss_done, uv, sw_tick;
    int n_errors = 0;
    int compares = 0;
    int ticks;
    int i;
    logic disch;
    bsfs_sequencer #(.FAST_VARIANT(1), .SS_CYCLES(SS), .DISCHARGE_CYCLES(DIS),
        .UV_FILTER_CYC(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .enable_above(enable_above), .feedback_input(fb),
        .pwm_high_req(pwm_high_req), .pwm_low_req(pwm_low_req),
        .high_gate(high_gate), .low_gate(low_gate), .ss_reference(ref_v),
        .ss_done(ss_done), .feedback_undervoltage_shutdown(uv),
        .sw_tick(sw_tick));
    bsfs_power_stage u_stage (.core_clk(core_clk), .high_gate(high_gate),
        .low_gate(low_gate), .ss_reference(ref_v), .short_on(short_on),
        .feedback_input(fb));
    initial forever #10 core_clk = ~core_clk;
    task check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task close_out;
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Reset stands for cycling the supply
    task power_cycle;
        rst_n = 1'b0;
        enable_above = 1'b0;
        short_on = 1'b0;
        clk(5);
        rst_n = 1'b1;
        clk(1);
    endtask
    task t_enable_drop;
        enable_above = 1'b1;
        for (i = 0; i < 4000 && ref_v < 4; i++) clk(1);
        enable_above = 1'b0;
        clk(1);
        check(ref_v, 0, "reference not cleared");
        check(high_gate, 0, "high gate on");
        clk(200);
        check({high_gate, ss_done}, 0, "not held off");
    endtask
    task t_startup;
        enable_above = 1'b1;
        ticks = 0;
        disch = 1'b0;
        for (i = 0; i < 4000 && ss_done !== 1'b1; i++) begin
            clk(1);
            ticks += sw_tick;
            disch |= (low_gate === 1'b1);
        end
        check(disch, 1, "no discharge");
        check(ticks, SS + DIS + 1, "tick count");
        check(ref_v, `BSFS_REF_FULL, "reference not full");
        // One cycle of low side only: too short for the filter to trip
        pwm_high_req = 1'b0;
        pwm_low_req = 1'b1;
        clk(1);
        check({high_gate, low_gate}, 2'b01, "low gate not passed");
        pwm_high_req = 1'b1;
        pwm_low_req = 1'b0;
        clk(1);
        check({high_gate, low_gate}, 2'b10, "high gate not passed");
    endtask
    task t_short_run;
        short_on = 1'b1;
        for (i = 0; i < 50 && uv !== 1'b1; i++) clk(1);
        check(uv, 1, "no fault in run");
        clk(1);
        check({high_gate, low_gate}, 0, "gates on");
        enable_above = 1'b0;
        clk(3);
        enable_above = 1'b1;
        short_on = 1'b0;
        clk(3000);
        check({uv, high_gate}, 2'b10, "latch released");
        power_cycle;
        check(uv, 0, "latch survives supply cycle");
    endtask
    task t_short_start;
        short_on = 1'b1;
        enable_above = 1'b1;
        for (i = 0; i < 4000 && uv !== 1'b1; i++) clk(1);
        check({uv, ss_done}, 2'b10, "no fault in ramp");
        check(ref_v, SS / 2, "fault outside half count");
    endtask
    initial begin
        power_cycle;
        t_enable_drop;
        t_startup;
        t_short_run;
        t_short_start;
        close_out;
    end
    initial begin
        clk(30000);
        n_errors++;
        close_out;
    end
endmodule
bind bsfs_sequencer bsfs_chk #(.FAST_VARIANT(FAST_VARIANT),
    .SS_CYCLES(SS_CYCLES)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .enable_above(enable_above), .feedback_input(feedback_input),
    .pwm_high_req(pwm_high_req), .pwm_low_req(pwm_low_req),
    .high_gate(high_gate), .low_gate(low_gate), .ss_reference(ss_reference),
    .ss_done(ss_done), .sw_tick(sw_tick),
    .feedback_undervoltage_shutdown(feedback_undervoltage_shutdown));
`default_nettype wire
